// ===== core/cas_pkg.sv
// Constants for the application selection and session block
package cas_pkg;
    // Register byte offsets and name length limits
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD  = 8'h04;
    localparam logic [7:0] OFS_CLEN = 8'h08;
    localparam logic [7:0] OFS_CAID = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h1C;
    localparam logic [7:0] OFS_RESP = 8'h20;
    localparam logic [7:0] OFS_VIEW = 8'h24;
    localparam logic [7:0] OFS_DIR  = 8'h34;
    localparam logic [7:0] OFS_ACFG = 8'h38;
    localparam logic [7:0] OFS_ASTG = 8'h3C;
    localparam logic [7:0] OFS_CAPS = 8'h4C;
    localparam int         AID_WORDS = 4;
    localparam int         AID_MAX   = 16;
    localparam logic [4:0] AID_MIN   = 5'h01;
    localparam logic [4:0] AID_TOP   = 5'h10;

    // Field positions
    localparam int CTRL_GO    = 0;
    localparam int CTRL_CRST  = 1;
    localparam int ACFG_LEN   = 8;
    localparam int ACFG_NEW   = 16;
    localparam int ACFG_SHR   = 17;
    localparam int ACFG_VAL   = 18;
    localparam int STAT_BUSY  = 16;
    localparam int STAT_NEW   = 17;
    localparam int STAT_LEG   = 18;
    localparam int STAT_RVLD  = 19;
    localparam int STAT_LERR  = 20;
    localparam int DIR_EOF    = 31;

    // Command bytes and P2 field values
    localparam logic [7:0] CLA_LEGACY  = 8'hA0;
    localparam logic [7:0] INS_SELECT  = 8'hA4;
    localparam logic [7:0] INS_STATUS  = 8'hF2;
    localparam logic [7:0] P1_BY_NAME  = 8'h04;
    localparam logic [7:0] P2_ST_FCP   = 8'h00;
    localparam logic [7:0] P2_ST_NAME  = 8'h01;
    localparam logic [1:0] OCC_FIRST   = 2'h0;
    localparam logic [1:0] OCC_LAST    = 2'h1;
    localparam logic [1:0] OCC_NEXT    = 2'h2;
    localparam logic [1:0] OCC_PREV    = 2'h3;
    localparam logic [1:0] SES_TERM    = 2'h2;

    // Status words, descriptors and capability bits
    localparam logic [15:0] SW_OK       = 16'h9000;
    localparam logic [15:0] SW_BAD_CLA  = 16'h6E00;
    localparam logic [15:0] SW_BAD_INS  = 16'h6D00;
    localparam logic [15:0] SW_BAD_LEN  = 16'h6700;
    localparam logic [15:0] SW_NOT_FND  = 16'h6A82;
    localparam logic [15:0] SW_BAD_P12  = 16'h6A86;
    localparam logic [15:0] SW_COND     = 16'h6985;
    localparam logic [15:0] SW_NONE     = 16'h0000;
    localparam logic [7:0]  FD_APP      = 8'h38;
    localparam logic [7:0]  FD_APP_SHR  = 8'h78;
    localparam logic [7:0]  CAP_FULL    = 8'h80;
    localparam logic [7:0]  CAP_PART    = 8'h40;

    typedef enum logic [0:0] {
        CAS_IDLE = 1'b0,
        CAS_EXEC = 1'b1
    } cas_state_type;
endpackage

// ===== core/cas_app_select.sv
// Application selection and session control with APB register access
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module cas_app_select #(
    parameter int NAPP    = 8,     // Application table entries
    parameter bit PART_EN = 1'b1   // Partial name selection enabled; always on when NAPP > 1
) (
    input  wire logic        clock,        // System clock
    input  wire logic        sys_rst,      // Async reset, active high
    input  wire logic        psel,         // APB select
    input  wire logic        penable,      // APB enable
    input  wire logic        pwrite,       // APB direction
    input  wire logic [7:0]  paddr,        // APB byte address
    input  wire logic [31:0] pwdata,       // APB write data
    output logic      [31:0] prdata,       // APB read data
    output logic             pready,       // APB ready
    output logic             pslverr,      // APB error
    output logic             app_reset,    // Session reset pulse
    output logic      [7:0]  app_reset_idx // Entry being reset
);
    localparam int IW = $clog2(NAPP);
    localparam int NCH = 4;

    typedef struct packed {
        logic [NAPP-1:0][cas_pkg::AID_MAX-1:0][7:0] aid;
        logic [NAPP-1:0][4:0]                       alen;
        logic [NAPP-1:0]                            anew;
        logic [NAPP-1:0]                            ashr;
        logic [NAPP-1:0]                            aval;
        logic [cas_pkg::AID_MAX-1:0][7:0]           stage;
        logic [cas_pkg::AID_MAX-1:0][7:0]           caid;
        logic [31:0]                                cmd;
        logic [4:0]                                 clen;
        logic [NCH-1:0]                             ch_act;
        logic [NCH-1:0][IW-1:0]                     ch_app;
        logic [IW-1:0]                              last_app;
        logic                                       last_vld;
        logic [15:0]                                sw;
        logic                                       resp_vld;
        logic [IW-1:0]                              view;
        logic [7:0]                                 fdesc;
        logic                                       load_err;
        logic [IW:0]                                dir_ptr;
        cas_pkg::cas_state_type                     state;
        logic [31:0]                                prdata;
        logic                                       pready;
        logic                                       pslverr;
        logic                                       app_rst;
    } cas_regs_type;

    cas_regs_type r_r;
    cas_regs_type r_nxt;

    assign prdata        = r_r.prdata;
    assign pready        = r_r.pready;
    assign pslverr       = r_r.pslverr;
    assign app_reset     = r_r.app_rst;
    assign app_reset_idx = 8'(r_r.view);

    logic [7:0]      cla;
    logic [7:0]      ins;
    logic [7:0]      p1;
    logic [7:0]      p2;
    logic [1:0]      chan;
    logic [NAPP-1:0] full_hit;
    logic [NAPP-1:0] part_hit;
    logic [NAPP-1:0] dup_hit;
    logic            new_act;
    logic            leg_act;

    assign cla  = r_r.cmd[7:0];
    assign ins  = r_r.cmd[15:8];
    assign p1   = r_r.cmd[23:16];
    assign p2   = r_r.cmd[31:24];
    assign chan = cla[1:0];

    // Name comparison against every table entry
    always_comb begin
        logic fe;
        logic pe;
        logic de;
        fe = 1'b0;
        pe = 1'b0;
        de = 1'b0;
        for (int i = 0; i < NAPP; i++) begin
            fe = r_r.aval[i] && (r_r.alen[i] == r_r.clen);
            pe = r_r.aval[i] && (r_r.clen != 5'h00) && (r_r.clen <= r_r.alen[i]);
            de = r_r.aval[i] && (r_r.alen[i] == pwdata[cas_pkg::ACFG_LEN +: 5]);
            for (int k = 0; k < cas_pkg::AID_MAX; k++) begin
                if (5'(k) < r_r.clen && r_r.aid[i][k] != r_r.caid[k]) begin
                    fe = 1'b0;
                    pe = 1'b0;
                end
                if (5'(k) < pwdata[cas_pkg::ACFG_LEN +: 5]
                    && r_r.aid[i][k] != r_r.stage[k]) begin
                    de = 1'b0;
                end
            end
            full_hit[i] = fe;
            part_hit[i] = pe;
            dup_hit[i]  = de && (IW'(i) != pwdata[IW-1:0]);
        end
    end

    always_comb begin
        new_act = 1'b0;
        leg_act = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            new_act = new_act || (r_r.ch_act[c] && r_r.anew[r_r.ch_app[c]]);
            leg_act = leg_act || (r_r.ch_act[c] && !r_r.anew[r_r.ch_app[c]]);
        end
    end

    always_comb begin
        logic          wr;
        logic          rd;
        logic          found;
        logic [IW-1:0] sel;
        logic [IW-1:0] cur;
        logic          cur_vld;
        logic [IW:0]   dn;
        logic          dfound;
        logic [7:0]    a;
        logic          part_ok;
        wr      = psel && penable && r_r.pready && pwrite;
        rd      = psel && penable && r_r.pready && !pwrite;
        found   = 1'b0;
        sel     = '0;
        cur     = r_r.ch_app[chan];
        cur_vld = r_r.ch_act[chan];
        dn      = '0;
        dfound  = 1'b0;
        a       = paddr;
        part_ok = PART_EN || (NAPP > 1);
        r_nxt   = r_r;
        r_nxt.app_rst = 1'b0;
        r_nxt.pready  = psel && !penable;
        r_nxt.pslverr = 1'b0;

        for (int i = NAPP - 1; i >= 0; i--) begin
            if (r_r.aval[i] && (IW+1)'(i) >= r_r.dir_ptr) begin
                dn     = (IW+1)'(i);
                dfound = 1'b1;
            end
        end

        // Read data captured in the setup cycle
        if (psel && !penable) begin
            r_nxt.prdata = '0;
            if (a == cas_pkg::OFS_CMD) begin
                r_nxt.prdata = r_r.cmd;
            end else if (a == cas_pkg::OFS_CLEN) begin
                r_nxt.prdata = 32'(r_r.clen);
            end else if (a >= cas_pkg::OFS_CAID && a < cas_pkg::OFS_STAT) begin
                r_nxt.prdata = r_r.caid[4 * 2'(a[3:2] - 2'h3) +: 4];
            end else if (a == cas_pkg::OFS_STAT) begin
                r_nxt.prdata[15:0]              = r_r.sw;
                r_nxt.prdata[cas_pkg::STAT_BUSY] = (r_r.state == cas_pkg::CAS_EXEC);
                r_nxt.prdata[cas_pkg::STAT_NEW]  = new_act;
                r_nxt.prdata[cas_pkg::STAT_LEG]  = leg_act;
                r_nxt.prdata[cas_pkg::STAT_RVLD] = r_r.resp_vld;
                r_nxt.prdata[cas_pkg::STAT_LERR] = r_r.load_err;
            end else if (a == cas_pkg::OFS_RESP) begin
                r_nxt.prdata = {11'h000, r_r.alen[r_r.view], 8'(r_r.view), r_r.fdesc};
            end else if (a >= cas_pkg::OFS_VIEW && a < cas_pkg::OFS_DIR) begin
                // name of the viewed entry (last selected, status or directory record) readable as response object
                r_nxt.prdata = r_r.aid[r_r.view][4 * 2'(a[3:2] - 2'h1) +: 4];
            end else if (a == cas_pkg::OFS_DIR) begin
                r_nxt.prdata = {!dfound, 15'h0000, 8'(dn), 3'h0, r_r.alen[dn[IW-1:0]]};
            end else if (a == cas_pkg::OFS_CAPS) begin
                r_nxt.prdata = {8'h00, cas_pkg::CAP_FULL | (part_ok ? cas_pkg::CAP_PART : 8'h00),
                                cas_pkg::CAP_FULL | (part_ok ? cas_pkg::CAP_PART : 8'h00),
                                7'h00, part_ok};
            end
            if (a[1:0] != 2'h0 || a > cas_pkg::OFS_CAPS) begin
                r_nxt.pslverr = 1'b1;
            end
        end

        // Reading the directory register advances the record pointer
        if (rd && a == cas_pkg::OFS_DIR && dfound) begin
            r_nxt.dir_ptr = dn + (IW+1)'(1);
            r_nxt.view    = dn[IW-1:0];
        end

        if (wr && r_r.state == cas_pkg::CAS_IDLE) begin
            if (a == cas_pkg::OFS_CMD) begin
                r_nxt.cmd = pwdata;
            end else if (a == cas_pkg::OFS_CLEN) begin
                r_nxt.clen = pwdata[4:0];
            end else if (a >= cas_pkg::OFS_CAID && a < cas_pkg::OFS_STAT) begin
                r_nxt.caid[4 * 2'(a[3:2] - 2'h3) +: 4] = pwdata;
            end else if (a >= cas_pkg::OFS_ASTG && a < cas_pkg::OFS_CAPS) begin
                r_nxt.stage[4 * 2'(a[3:2] - 2'h3) +: 4] = pwdata;
            end else if (a == cas_pkg::OFS_DIR) begin
                r_nxt.dir_ptr = '0;
            end else if (a == cas_pkg::OFS_ACFG) begin
                if (pwdata[cas_pkg::ACFG_VAL]
                    && (pwdata[cas_pkg::ACFG_LEN +: 5] < cas_pkg::AID_MIN
                        || pwdata[cas_pkg::ACFG_LEN +: 5] > cas_pkg::AID_TOP
                        || dup_hit != '0)) begin
                    r_nxt.load_err = 1'b1;
                end else begin
                    r_nxt.load_err                   = 1'b0;
                    r_nxt.aid[pwdata[IW-1:0]]  = r_r.stage;
                    r_nxt.alen[pwdata[IW-1:0]] = pwdata[cas_pkg::ACFG_LEN +: 5];
                    r_nxt.anew[pwdata[IW-1:0]] = pwdata[cas_pkg::ACFG_NEW];
                    r_nxt.ashr[pwdata[IW-1:0]] = pwdata[cas_pkg::ACFG_SHR];
                    r_nxt.aval[pwdata[IW-1:0]] = pwdata[cas_pkg::ACFG_VAL];
                end
            end else if (a == cas_pkg::OFS_CTRL) begin
                if (pwdata[cas_pkg::CTRL_CRST]) begin
                    r_nxt.ch_act   = '0;
                    r_nxt.resp_vld = 1'b0;
                    r_nxt.sw       = cas_pkg::SW_NONE;
                end else if (pwdata[cas_pkg::CTRL_GO]) begin
                    r_nxt.state = cas_pkg::CAS_EXEC;
                end
            end
        end

        // Occurrence search
        if (full_hit != '0) begin
            for (int i = NAPP - 1; i >= 0; i--) begin
                if (full_hit[i]) begin
                    sel   = IW'(i);
                    found = 1'b1;
                end
            end
        end else if (part_ok) begin
            case (p2[1:0])
                cas_pkg::OCC_FIRST: begin
                    for (int i = NAPP - 1; i >= 0; i--) begin
                        if (part_hit[i]) begin
                            sel   = IW'(i);
                            found = 1'b1;
                        end
                    end
                end
                cas_pkg::OCC_LAST: begin
                    found = r_r.last_vld && part_hit[r_r.last_app];
                    sel   = r_r.last_app;
                end
                cas_pkg::OCC_NEXT: begin
                    for (int i = NAPP - 1; i >= 0; i--) begin
                        if (part_hit[i] && (!cur_vld || IW'(i) > cur)) begin
                            sel   = IW'(i);
                            found = 1'b1;
                        end
                    end
                end
                cas_pkg::OCC_PREV: begin
                    for (int i = 0; i < NAPP; i++) begin
                        if (part_hit[i] && (!cur_vld || IW'(i) < cur)) begin
                            sel   = IW'(i);
                            found = 1'b1;
                        end
                    end
                end
                default: found = 1'b0;
            endcase
        end

        case (r_r.state)
            cas_pkg::CAS_IDLE: begin
            end
            cas_pkg::CAS_EXEC: begin
                r_nxt.state = cas_pkg::CAS_IDLE;
                if (cla == cas_pkg::CLA_LEGACY && new_act) begin
                    r_nxt.sw = cas_pkg::SW_BAD_CLA;
                end else if (ins == cas_pkg::INS_STATUS) begin
                    if (p2 == cas_pkg::P2_ST_NAME || p2 == cas_pkg::P2_ST_FCP) begin
                        r_nxt.sw       = cas_pkg::SW_OK;
                        r_nxt.resp_vld = cur_vld;
                        r_nxt.view     = cur;
                        r_nxt.fdesc    = r_r.ashr[cur] ? cas_pkg::FD_APP_SHR : cas_pkg::FD_APP;
                    end else begin
                        r_nxt.sw = cas_pkg::SW_BAD_P12;
                    end
                end else if (ins != cas_pkg::INS_SELECT) begin
                    r_nxt.sw = cas_pkg::SW_BAD_INS;
                end else if (p1 != cas_pkg::P1_BY_NAME) begin
                    r_nxt.sw = cas_pkg::SW_BAD_P12;
                end else if (r_r.clen < cas_pkg::AID_MIN || r_r.clen > cas_pkg::AID_TOP) begin
                    r_nxt.sw = cas_pkg::SW_BAD_LEN;
                end else if (!found) begin
                    r_nxt.sw = cas_pkg::SW_NOT_FND;
                end else if (p2[6:5] == cas_pkg::SES_TERM) begin
                    if (cur_vld && cur == sel) begin
                        r_nxt.ch_act[chan] = 1'b0;
                        r_nxt.resp_vld     = 1'b0;
                        r_nxt.sw           = cas_pkg::SW_OK;
                    end else begin
                        r_nxt.sw = cas_pkg::SW_COND;
                    end
                end else if ((r_r.anew[sel] && leg_act && !(cur_vld && !r_r.anew[cur]))
                             || (!r_r.anew[sel] && new_act && !(cur_vld && r_r.anew[cur]))
                             || (r_r.anew[sel] && cla == cas_pkg::CLA_LEGACY)) begin
                    r_nxt.sw = cas_pkg::SW_COND;
                end else begin
                    r_nxt.app_rst      = cur_vld && cur == sel;
                    r_nxt.ch_act[chan] = 1'b1;
                    r_nxt.ch_app[chan] = sel;
                    r_nxt.last_app     = sel;
                    r_nxt.last_vld     = 1'b1;
                    r_nxt.sw       = cas_pkg::SW_OK;
                    r_nxt.resp_vld = 1'b1;
                    r_nxt.view     = sel;
                    r_nxt.fdesc    = r_r.ashr[sel] ? cas_pkg::FD_APP_SHR : cas_pkg::FD_APP;
                end
            end
            default: r_nxt.state = cas_pkg::CAS_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end
endmodule

// ===== dv/cas_terminal_model.sv
// Terminal-side model that records session restart pulses
`timescale 1ns/1ns
module cas_terminal_model (
    input  wire logic       clock,    // Clock
    input  wire logic       sys_rst,  // Reset
    input  wire logic       app_rst,  // Restart pulse
    input  wire logic [7:0] app_idx,  // Restarted entry
    output logic      [7:0] restarts, // Pulse count
    output logic      [7:0] last_idx  // Last entry
);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            restarts <= 8'h00;
            last_idx <= 8'h00;
        end else if (app_rst) begin
            restarts <= restarts + 8'h01;
            last_idx <= app_idx;
        end
    end
endmodule

// ===== dv/cas_app_select_monitor.sv
// Port checker for the application selection block
`timescale 1ns/1ns
module cas_app_select_monitor #(
    parameter int NAPP    = 8,   // Table entries
    parameter bit PART_EN = 1'b1 // Partial selection
) (
    input wire logic        clock,        // Clock
    input wire logic        sys_rst,      // Reset
    input wire logic        psel,         // Select
    input wire logic        penable,      // Enable
    input wire logic        pwrite,       // Direction
    input wire logic [7:0]  paddr,        // Address
    input wire logic [31:0] pwdata,       // Write data
    input wire logic [31:0] prdata,       // Read data
    input wire logic        pready,       // Ready
    input wire logic        pslverr,      // Error
    input wire logic        app_reset,    // Restart pulse
    input wire logic [7:0]  app_reset_idx // Entry
);
    logic [3:0] since_go_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    // Cycles since a command start
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            since_go_r <= 4'hF;
        end else if (psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[0]) begin
            since_go_r <= 4'h0;
        end else if (since_go_r != 4'hF) begin
            since_go_r <= since_go_r + 4'h1;
        end
    end
    ready_after_setup_a: assert property (setup_s |=> access_s)
        else $error("pready missing after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (setup_s and paddr > 8'h4C |=> pslverr)
        else $error("unmapped address accepted");
    unaligned_err_a: assert property (setup_s and paddr[1:0] != 2'h0 |=> pslverr)
        else $error("unaligned address accepted");
    mapped_ok_a: assert property (setup_s and paddr[1:0] == 2'h0 && paddr <= 8'h4C |=> !pslverr)
        else $error("mapped address refused");
    restart_pulse_a: assert property (app_reset |=> !app_reset)
        else $error("restart pulse too long");
    restart_cause_a: assert property (app_reset |-> since_go_r <= 4'h3)
        else $error("restart without command");
endmodule
bind cas_app_select cas_app_select_monitor #(.NAPP(NAPP), .PART_EN(PART_EN)) u_mon (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .app_reset(app_reset), .app_reset_idx(app_reset_idx));

// ===== dv/tb_top.sv
// Self-checking bench for application selection and sessions
`timescale 1ns/1ns
module tb_top;
    localparam logic [31:0] N0 = 32'h04030201;
    localparam logic [31:0] N1 = 32'h14131211;
    localparam logic [31:0] NA = 32'h00020000;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, app_reset, err;
    logic [7:0]  app_reset_idx, restarts, last_idx;
    int          n_fail = 0;
    int          compares = 0;
    always #5 clock = ~clock;
    cas_app_select i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .app_reset(app_reset), .app_reset_idx(app_reset_idx));
    cas_terminal_model i_term (.clock(clock), .sys_rst(sys_rst), .app_rst(app_reset),
        .app_idx(app_reset_idx), .restarts(restarts), .last_idx(last_idx));
    task automatic end_of_test();
        $display("n_fail %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(rd & m, e);
    endtask
    task automatic ld(input logic [31:0] nm, input logic [31:0] cfg);
        apb(1'b1, cas_pkg::OFS_ASTG, nm);
        apb(1'b1, cas_pkg::OFS_ACFG, cfg);
    endtask
    task automatic run(input logic [31:0] c, input logic [4:0] n, input logic [31:0] nm,
                       input logic [15:0] sw);
        apb(1'b1, cas_pkg::OFS_CMD, c);
        apb(1'b1, cas_pkg::OFS_CLEN, {27'h0, n});
        apb(1'b1, cas_pkg::OFS_CAID, nm);
        apb(1'b1, cas_pkg::OFS_CTRL, 32'h1);
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, cas_pkg::OFS_STAT, 32'h0);
            if (rd[16] === 1'b0) break;
        end
        cmp({15'h0, rd[16:0]}, {16'h0, sw});
    endtask
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        ld(N0, 32'h00050400);
        ld(N1, 32'h00070401);
        ld(N1, 32'h00050002);
        rdc(cas_pkg::OFS_STAT, 32'h00100000, 32'h00100000);
        ld(N0, 32'h00050402);
        rdc(cas_pkg::OFS_STAT, 32'h00100000, 32'h00100000);
        apb(1'b1, cas_pkg::OFS_DIR, 32'h0);
        for (int i = 0; i < 2; i++) begin
            rdc(cas_pkg::OFS_DIR, 32'h8000FF1F, {16'h0, i[7:0], 8'h04});
        end
        rdc(cas_pkg::OFS_DIR, 32'h80000000, 32'h80000000);
        rdc(cas_pkg::OFS_CAPS, 32'h1, 32'h1);
        apb(1'b0, 8'h50, 32'h0);
        cmp({31'h0, err}, 32'h1);
        apb(1'b0, 8'h0D, 32'h0);
        cmp({31'h0, err}, 32'h1);
        run(32'h0004A400, 5'h04, N0, 16'h9000);
        rdc(cas_pkg::OFS_RESP, 32'hFF, 32'h38);
        rdc(cas_pkg::OFS_VIEW, 32'hFFFFFFFF, N0);
        rdc(cas_pkg::OFS_STAT, 32'h00060000, NA);
        run(32'h0100F280, 5'h00, 32'h0, 16'h9000);
        rdc(cas_pkg::OFS_VIEW, 32'hFFFFFFFF, N0);
        run(32'h0100F2A0, 5'h00, 32'h0, 16'h6E00);
        run(32'h0004A400, 5'h04, N0, 16'h9000);
        cmp({24'h0, restarts}, 32'h1);
        cmp({24'h0, last_idx}, 32'h0);
        run(32'h0004A400, 5'h04, 32'h0A0B0C0D, 16'h6A82);
        rdc(cas_pkg::OFS_STAT, NA, NA);
        run(32'h0004A400, 5'h00, 32'h0, 16'h6700);
        run(32'h0004A400, 5'h04, N1, 16'h9000);
        rdc(cas_pkg::OFS_RESP, 32'hFF, 32'h78);
        rdc(cas_pkg::OFS_VIEW, 32'hFFFFFFFF, N1);
        rdc(cas_pkg::OFS_STAT, 32'h00060000, NA);
        run(32'h0004A400, 5'h04, N1, 16'h9000);
        cmp({24'h0, restarts}, 32'h2);
        cmp({24'h0, last_idx}, 32'h1);
        run(32'h4004A400, 5'h04, N1, 16'h9000);
        rdc(cas_pkg::OFS_STAT, NA, 32'h0);
        run(32'h0000F200, 5'h00, 32'h0, 16'h9000);
        rdc(cas_pkg::OFS_STAT, 32'h00080000, 32'h0);
        run(32'h0004A400, 5'h04, N1, 16'h9000);
        apb(1'b1, cas_pkg::OFS_CTRL, 32'h2);
        rdc(cas_pkg::OFS_STAT, 32'h000E0000, 32'h0);
        run(32'h0104A400, 5'h02, 32'h1211, 16'h9000);
        rdc(cas_pkg::OFS_VIEW, 32'hFFFFFFFF, N1);
        run(32'h0004A400, 5'h02, 32'h0201, 16'h9000);
        rdc(cas_pkg::OFS_VIEW, 32'hFFFFFFFF, N0);
        ld(32'h24232221, 32'h00040402);
        run(32'h0004A401, 5'h04, 32'h24232221, 16'h6985);
        run(32'h0204A400, 5'h01, 32'h01, 16'h6A82);
        run(32'h0304A400, 5'h01, 32'h01, 16'h6A82);
        apb(1'b1, cas_pkg::OFS_CTRL, 32'h2);
        run(32'h0004A401, 5'h04, 32'h24232221, 16'h9000);
        rdc(cas_pkg::OFS_STAT, 32'h00060000, 32'h00040000);
        run(32'h0004A400, 5'h04, N0, 16'h6985);
        end_of_test();
    end
endmodule
